// [sbw_checker.sv]
`timescale 1ns/1ps
// ********
// Agent side checks
// ********
module sbw_checker (
	input wire clock,
	input wire rst,
	input wire bus_wide,
	input wire proc_valid_n,
	input wire [8:0] command_bus,
	input wire [63:0] addr_data_bus,
	input wire write_accept_n,
	input wire proto_error,
	input wire out_valid,
	input wire out_ready,
	input wire [31:0] out_addr,
	input wire [7:0] out_lanes,
	input wire out_block
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_byte_wr;
		!proc_valid_n && command_bus == 9'h058 && addr_data_bus[2:0] == 3'h0;
	endsequence
	sequence s_data;
		!proc_valid_n && command_bus[8];
	endsequence
	a_reset_quiet: assert property ($fell(rst) |->
		write_accept_n && !out_valid ##1 write_accept_n) else $error("reset");
	a_head_holds: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_addr) && $stable(out_lanes)) else $error("head");
	a_block_wide: assert property (out_valid && out_block && bus_wide |->
		out_lanes == 8'hff) else $error("wide lanes");
	a_narrow_lanes: assert property (out_valid && !bus_wide |->
		out_lanes[7:4] == 4'h0 && (!out_block || out_lanes == 8'h0f))
		else $error("narrow lanes");
	a_block_align: assert property (out_valid && out_block |->
		out_addr[1:0] == 2'h0 && !(bus_wide && out_addr[2])) else $error("align");
	a_single_lanes: assert property (out_valid && !out_block |->
		out_lanes != 8'h00) else $error("no lanes");
	a_null_quiet: assert property (!proc_valid_n &&
		command_bus[8:5] == 4'h3 |=> !proto_error) else $error("null");
	a_byte_clean: assert property (s_byte_wr ##1 s_data |->
		!proto_error ##1 !proto_error) else $error("byte write");
endmodule // sbw_checker

bind sbw_write_agent sbw_checker u_chk (
	.clock(clock),
	.rst(rst),
	.bus_wide(bus_wide),
	.proc_valid_n(proc_valid_n),
	.command_bus(command_bus),
	.addr_data_bus(addr_data_bus),
	.write_accept_n(write_accept_n),
	.proto_error(proto_error),
	.out_valid(out_valid),
	.out_ready(out_ready),
	.out_addr(out_addr),
	.out_lanes(out_lanes),
	.out_block(out_block)
);

// [sbw_defines.vh]
`ifndef SBW_DEFINES_VH
`define SBW_DEFINES_VH

// ****************************************
// Command bus layout
// ****************************************
`define SBW_CMD_W 9
`define SBW_CMD_DATA_BIT 8
`define SBW_TYPE_HI 7
`define SBW_TYPE_LO 5
`define SBW_ATTR_HI 4
`define SBW_ATTR_LO 3
`define SBW_REPL_BIT 2
`define SBW_SIZE_HI 2
`define SBW_SIZE_LO 0
`define SBW_BSIZE_HI 1
`define SBW_BSIZE_LO 0

// ****************************************
// Command encodings
// ****************************************
`define SBW_TYPE_READ 3'h0
`define SBW_TYPE_WRITE 3'h2
`define SBW_TYPE_NULL 3'h3
`define SBW_ATTR_BLOCK 2'h2
`define SBW_ATTR_SINGLE 2'h3
`define SBW_BSIZE_8W 2'h1

// ****************************************
// Bus and buffer figures
// ****************************************
`define SBW_AD_W 64
`define SBW_ADDR_W 32
`define SBW_LANES 8
`define SBW_BEATS_64 4'h4
`define SBW_BEATS_32 4'h8
`define SBW_STEP_64 32'h8
`define SBW_STEP_32 32'h4
`define SBW_MAX_BEATS 6'h08
`define SBW_ISSUE_LAG 2
`define SBW_STAGE_DEPTH 32
`define SBW_STAGE_AW 5
`define SBW_FIFO_DEPTH 4
`define SBW_ENTRY_W 106

`endif

// [sbw_fifo.v]
`timescale 1ns/1ps
`include "sbw_defines.vh"

// ****************************************
// Shift FIFO, head entry held in flops
// ****************************************
module sbw_fifo #(
	parameter WIDTH = `SBW_ENTRY_W,
	parameter DEPTH = `SBW_FIFO_DEPTH
) (
	input wire clock,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [DEPTH-1:0] vld_q;
	wire pop;
	wire push;
	integer i;

	assign out_valid = vld_q[0];
	assign out_data = mem_q[0];
	// Full is the last slot taken; a pop in the same cycle is not credited
	assign in_ready = ~vld_q[DEPTH-1];
	assign pop = vld_q[0] & out_ready;
	assign push = in_valid & ~vld_q[DEPTH-1];

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			vld_q <= {DEPTH{1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= {WIDTH{1'b0}};
			end
		end else begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				if (pop) begin
					if (i == DEPTH - 1) begin
						vld_q[i] <= push & vld_q[i];
						mem_q[i] <= in_data;
					end else if (push & vld_q[i] & ~vld_q[i+1]) begin
						vld_q[i] <= 1'b1;
						mem_q[i] <= in_data;
					end else begin
						vld_q[i] <= vld_q[i+1];
						mem_q[i] <= mem_q[i+1];
					end
				end else if (push & ~vld_q[i] &
						((i == 0) || vld_q[i-1])) begin
					vld_q[i] <= 1'b1;
					mem_q[i] <= in_data;
				end
			end
		end
	end
endmodule // sbw_fifo

// [sbw_proc_model.sv]
`timescale 1ns/1ps
// ********
// Processor side of the write bus
// ********
module sbw_proc_model (
	input wire clock,
	input wire bus_wide,
	input wire write_accept_n,
	output reg proc_valid_n,
	output reg [8:0] command_bus,
	output reg [63:0] addr_data_bus
);
	reg acc_q;
	initial begin
		proc_valid_n = 1'b1;
		command_bus = 9'h1ff;
		addr_data_bus = 64'h0;
		acc_q = 1'b1;
	end
	always @(posedge clock) acc_q <= write_accept_n;
	task rest;
		begin
			@(posedge clock);
			proc_valid_n <= 1'b1;
			addr_data_bus <= ~addr_data_bus;
		end
	endtask
	task send(input [8:0] cmd, input [31:0] a, input [3:0] n, input [63:0] d);
		integer i;
		begin
			@(posedge clock);
			// Held-off write waits with the bus released
			while (acc_q !== 1'b0) begin
				proc_valid_n <= 1'b1;
				addr_data_bus <= ~addr_data_bus;
				@(posedge clock);
			end
			proc_valid_n <= 1'b0;
			command_bus <= cmd;
			addr_data_bus <= {32'h0, a};
			for (i = 0; i < n; i = i + 1) begin
				@(posedge clock);
				// Identifier bits other than bit 8 toggle; agent ignores them
				command_bus <= {1'b1, i[0] ? 8'hff : 8'h00};
				addr_data_bus <= d + i;
			end
		end
	endtask
	task single(input [31:0] a, input [63:0] d, input [3:0] nb);
		send({4'h2, 2'h3, nb[2:0] - 3'h1}, a, 4'h1, d);
	endtask
	task block(input [31:0] a, input kp, input [63:0] d);
		send({4'h2, 2'h2, kp, 2'h1}, a, bus_wide ? 4'h4 : 4'h8, d);
	endtask
endmodule // sbw_proc_model

// [sbw_write_agent.v]
`timescale 1ns/1ps
`include "sbw_defines.vh"

// Functional notes
// - Agent accepts up to two more writes after raising ready.
// - Issue rules cover single and block writes; single may precede block.
// - In 32-bit mode agent takes eight words in sequence at full rate.
// - 64-bit lanes from address mod 8 and size, endian dependent.
// - 64-bit legal offsets per size, others are protocol errors.
// - 32-bit lanes from address mod 4; big endian offset 0 is 31:24.
// - Same command encoding in both widths; width fixed at reset.
// - Agent drives reserved bits one; ignores processor reserved bits.
// - Command bit 8 is 0 in address cycles, 1 in data cycles.
// - Bits 7:5 give type: 0 read, 2 write, 3 null.
// - Bits 4:3 give 2 block write, 3 single write.
module sbw_write_agent (
	input wire clock,
	input wire rst,
	input wire bus_wide,
	input wire big_endian,
	input wire proc_valid_n,
	input wire [`SBW_CMD_W-1:0] command_bus,
	input wire [`SBW_AD_W-1:0] addr_data_bus,
	output reg write_accept_n,
	output reg proto_error,
	output wire out_valid,
	input wire out_ready,
	output wire [`SBW_ADDR_W-1:0] out_addr,
	output wire [`SBW_AD_W-1:0] out_data,
	output wire [`SBW_LANES-1:0] out_lanes,
	output wire out_block,
	output wire out_keep_line
);
	// ****************************************
	// Lane decode for partial writes
	// ****************************************
	// Returns {legal, lane mask}; mask bit k covers data bits 8k+7:8k
	function [8:0] lane_decode;
		input [2:0] size;
		input [2:0] off;
		input wide;
		input big;
		reg [3:0] n;
		reg [15:0] m;
		reg [7:0] r;
		reg ok;
		reg [2:0] o;
		integer k;
		begin
			n = {1'b0, size} + 4'h1;
			// Narrow bus sees address mod 4; bit 2 only picks the word
			o = wide ? off : {1'b0, off[1:0]};
			m = ((16'h1 << n) - 16'h1) << o;
			r = 8'h00;
			case (size)
				3'h0: ok = 1'b1;
				3'h1: ok = ~off[0];
				3'h2: ok = (off[1:0] <= 2'h1);
				3'h3: ok = (off[1:0] == 2'h0);
				default: ok = wide & ((off == 3'h0) ||
					({1'b0, off} + n == 4'h8));
			endcase
			if (!wide) begin
				ok = ok & ~size[2];
			end
			for (k = 0; k < 8; k = k + 1) begin
				if (wide) begin
					r[k] = big ? m[7-k] : m[k];
				end else if (k < 4) begin
					r[k] = big ? m[3-k] : m[k];
				end
			end
			lane_decode = {ok, r};
		end
	endfunction

	// ****************************************
	// Strap capture and beat tracking
	// ****************************************
	reg strap_done_q;
	reg wide_q;
	reg big_q;
	reg [3:0] beats_left_q;
	reg [3:0] beats_left_d;
	reg [`SBW_ADDR_W-1:0] beat_addr_q;
	reg keep_q;
	reg single_q;
	reg [7:0] single_lanes_q;
	reg [1:0] grant_hist_q;
	reg push_d;
	reg [`SBW_ENTRY_W-1:0] push_entry;
	reg err_d;
	reg [8:0] dec;
	wire addr_cycle;
	wire data_cycle;
	wire [2:0] cmd_type;
	wire [1:0] cmd_attr;
	wire [`SBW_ADDR_W-1:0] step;

	assign addr_cycle = ~proc_valid_n &
		~command_bus[`SBW_CMD_DATA_BIT];
	assign data_cycle = ~proc_valid_n &
		command_bus[`SBW_CMD_DATA_BIT];
	assign cmd_type = command_bus[`SBW_TYPE_HI:`SBW_TYPE_LO];
	assign cmd_attr = command_bus[`SBW_ATTR_HI:`SBW_ATTR_LO];
	assign step = wide_q ? `SBW_STEP_64 : `SBW_STEP_32;

	always @* begin
		beats_left_d = beats_left_q;
		push_d = 1'b0;
		err_d = 1'b0;
		push_entry = {`SBW_ENTRY_W{1'b0}};
		dec = lane_decode(command_bus[`SBW_SIZE_HI:`SBW_SIZE_LO],
			addr_data_bus[2:0], wide_q, big_q);
		// Reserved bits and reserved types pass unexamined
		if (addr_cycle && cmd_type == `SBW_TYPE_WRITE) begin
			if (cmd_attr == `SBW_ATTR_BLOCK) begin
				if (command_bus[`SBW_BSIZE_HI:`SBW_BSIZE_LO] ==
						`SBW_BSIZE_8W) begin
					beats_left_d = wide_q ? `SBW_BEATS_64 :
						`SBW_BEATS_32;
				end else begin
					err_d = 1'b1;
				end
			end else if (cmd_attr == `SBW_ATTR_SINGLE) begin
				beats_left_d = 4'h1;
				err_d = ~dec[8];
			end
		end else if (data_cycle && beats_left_q != 4'h0) begin
			push_d = 1'b1;
			beats_left_d = beats_left_q - 4'h1;
			push_entry = {beat_addr_q, addr_data_bus,
				single_q ? single_lanes_q :
				(wide_q ? 8'hff : 8'h0f), ~single_q, keep_q};
		end else if (data_cycle) begin
			err_d = 1'b1;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			strap_done_q <= 1'b0;
			wide_q <= 1'b0;
			big_q <= 1'b0;
			beats_left_q <= 4'h0;
			beat_addr_q <= 32'h0;
			keep_q <= 1'b0;
			single_q <= 1'b0;
			single_lanes_q <= 8'h00;
			proto_error <= 1'b0;
		end else begin
			// Width and endianness fixed once, first edge after reset
			if (!strap_done_q) begin
				strap_done_q <= 1'b1;
				wide_q <= bus_wide;
				big_q <= big_endian;
			end
			proto_error <= err_d;
			beats_left_q <= beats_left_d;
			if (addr_cycle) begin
				beat_addr_q <= addr_data_bus[`SBW_ADDR_W-1:0];
				keep_q <= command_bus[`SBW_REPL_BIT];
				single_q <= (cmd_attr == `SBW_ATTR_SINGLE);
				single_lanes_q <= dec[7:0];
			end else if (push_d) begin
				beat_addr_q <= beat_addr_q + step;
			end
		end
	end

	// ****************************************
	// Staging store ahead of the FIFO
	// ****************************************
	// Deep enough for every write the processor may still issue
	reg [`SBW_ENTRY_W-1:0] stage_q [0:`SBW_STAGE_DEPTH-1];
	reg [`SBW_STAGE_AW-1:0] wr_ptr_q;
	reg [`SBW_STAGE_AW-1:0] rd_ptr_q;
	reg [5:0] count_q;
	wire fifo_in_ready;
	wire stage_pop;
	wire [5:0] count_next;
	wire [5:0] free_next;
	wire [5:0] need;
	wire grant_d;
	wire [`SBW_ENTRY_W-1:0] fifo_out;

	assign stage_pop = (count_q != 6'h00) & fifo_in_ready;
	assign count_next = count_q + {5'h00, push_d} - {5'h00, stage_pop};
	assign free_next = 6'h20 - count_next;
	// One block per grant still in flight, one for this grant, plus rest
	assign need = `SBW_MAX_BEATS * ({4'h0, grant_hist_q[0]} +
		{4'h0, grant_hist_q[1]} + 6'h01) + {2'h0, beats_left_d};
	assign grant_d = strap_done_q & (free_next >= need);

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= 5'h00;
			rd_ptr_q <= 5'h00;
			count_q <= 6'h00;
			grant_hist_q <= 2'h0;
			write_accept_n <= 1'b1;
		end else begin
			if (push_d) begin
				wr_ptr_q <= wr_ptr_q + 5'h01;
			end
			if (stage_pop) begin
				rd_ptr_q <= rd_ptr_q + 5'h01;
			end
			count_q <= count_next;
			// Held low across cycles allows back-to-back issue
			grant_hist_q <= {grant_hist_q[0], grant_d};
			write_accept_n <= ~grant_d;
		end
	end

	// Store kept out of reset; stage_q[rd_ptr_q] is only taken while count_q is nonzero
	always @(posedge clock) begin
		if (push_d) begin
			stage_q[wr_ptr_q] <= push_entry;
		end
	end

	sbw_fifo #(
		.WIDTH(`SBW_ENTRY_W),
		.DEPTH(`SBW_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(count_q != 6'h00),
		.in_ready(fifo_in_ready),
		.in_data(stage_q[rd_ptr_q]),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(fifo_out)
	);

	assign out_addr = fifo_out[105:74];
	assign out_data = fifo_out[73:10];
	assign out_lanes = fifo_out[9:2];
	assign out_block = fifo_out[1];
	assign out_keep_line = fifo_out[0];
endmodule // sbw_write_agent

// [system_bus_write_port_test.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	$display("ERROR %s exp %h got %h", n, e, g); bad_count++; end end
// ********
// Write agent bench
// ********
module system_bus_write_port_test;
	reg clock, rst, bus_wide, big_endian, out_ready;
	wire proc_valid_n, write_accept_n, proto_error, out_valid, out_block;
	wire out_keep_line;
	wire [8:0] command_bus;
	wire [63:0] addr_data_bus, out_data;
	wire [31:0] out_addr;
	wire [7:0] out_lanes;
	int bad_count, comparisons, errs, held;
	reg [105:0] exq[$];
	sbw_write_agent u_dut (
		.clock(clock),
		.rst(rst),
		.bus_wide(bus_wide),
		.big_endian(big_endian),
		.proc_valid_n(proc_valid_n),
		.command_bus(command_bus),
		.addr_data_bus(addr_data_bus),
		.write_accept_n(write_accept_n),
		.proto_error(proto_error),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_addr(out_addr),
		.out_data(out_data),
		.out_lanes(out_lanes),
		.out_block(out_block),
		.out_keep_line(out_keep_line)
	);
	sbw_proc_model u_proc (
		.clock(clock),
		.bus_wide(bus_wide),
		.write_accept_n(write_accept_n),
		.proc_valid_n(proc_valid_n),
		.command_bus(command_bus),
		.addr_data_bus(addr_data_bus)
	);
	task close_out;
		begin
			$display("checks %0d mismatches %0d", comparisons, bad_count);
			if (bad_count == 0 && comparisons > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (proto_error === 1'b1) errs++;
		if (write_accept_n === 1'b1) held++;
	end
	task do_reset(input w, input be);
		begin
			rst <= 1'b1;
			bus_wide <= w;
			big_endian <= be;
			repeat (4) @(posedge clock);
			rst <= 1'b0;
			repeat (3) @(posedge clock);
			errs = 0;
		end
	endtask
	task wr1(input [31:0] a, input [63:0] d, input [3:0] nb, input [7:0] l);
		reg [2:0] s;
		begin
			s = nb[2:0] - 3'h1;
			exq.push_back({a, d, l, 1'b0, s[2]});
			u_proc.single(a, d, nb);
		end
	endtask
	task wrb(input [31:0] a, input kp, input [63:0] d);
		int i;
		begin
			for (i = 0; i < (bus_wide ? 4 : 8); i++)
				exq.push_back({a + i * (bus_wide ? 8 : 4), d + i,
					bus_wide ? 8'hff : 8'h0f, 1'b1, kp});
			u_proc.block(a, kp, d);
		end
	endtask
	task drain(input int k);
		reg [105:0] e;
		int t;
		repeat (k) begin
			e = exq.pop_front();
			t = 0;
			while (out_valid !== 1'b1 && t < 300) begin
				@(posedge clock);
				t++;
			end
			`CHK("out_valid", 1'b1, out_valid)
			`CHK("addr", e[105:74], out_addr)
			`CHK("data", e[73:10], out_data)
			`CHK("lanes", e[9:2], out_lanes)
			`CHK("block", e[1], out_block)
			`CHK("keep", e[0], out_keep_line)
			out_ready <= 1'b1;
			@(posedge clock);
			out_ready <= 1'b0;
			@(posedge clock);
		end
	endtask
	task t_wide_be;
		do_reset(1'b1, 1'b1);
		wr1(32'h103, 64'h1122, 4'h1, 8'h10);
		wrb(32'h200, 1'b1, 64'ha0);
		u_proc.rest;
		drain(5);
		`CHK("errors", 0, errs)
		$display("wide big endian done");
	endtask
	task t_wide_le;
		int i;
		do_reset(1'b1, 1'b0);
		for (i = 1; i <= 8; i++)
			wr1(32'h308 - i, 64'h30 + i, i[3:0], 8'hff << (8 - i));
		// Illegal offset still yields one stored beat
		wr1(32'h401, 64'h44, 4'h2, 8'h06);
		repeat (3) u_proc.rest;
		u_proc.send(9'h060, 32'h0, 4'h0, 64'h0);
		repeat (3) u_proc.rest;
		u_proc.send(9'h100, 32'h0, 4'h0, 64'h0);
		repeat (3) u_proc.rest;
		// Block write with a reserved block size
		u_proc.send(9'h050, 32'h0, 4'h0, 64'h0);
		repeat (3) u_proc.rest;
		drain(9);
		`CHK("errors", 3, errs)
		$display("wide little endian done");
	endtask
	task t_narrow;
		do_reset(1'b0, 1'b1);
		fork
			begin
				wr1(32'h500, 64'h55, 4'h1, 8'h08);
				wr1(32'h506, 64'h56, 4'h2, 8'h03);
				repeat (4) wrb(32'h600, 1'b0, 64'h60);
				u_proc.rest;
			end
			begin
				repeat (20) @(posedge clock);
				held = 0;
				repeat (60) @(posedge clock);
				`CHK("held off", 1'b1, held > 0)
				drain(34);
			end
		join
		`CHK("errors", 0, errs)
		$display("narrow big endian done");
	endtask
	initial begin
		rst = 1'b1;
		bus_wide = 1'b1;
		big_endian = 1'b0;
		out_ready = 1'b0;
		t_wide_be;
		t_wide_le;
		t_narrow;
		close_out;
	end
	initial begin
		repeat (5000) @(posedge clock);
		bad_count++;
		close_out;
	end
endmodule // system_bus_write_port_test
